// file: src/lcdcr_consts.svh
// register indices, field positions, reset values of the lcd control block
`ifndef LCDCR_CONSTS_SVH
`define LCDCR_CONSTS_SVH

`define LCDCR_ADDR_W        20
`define LCDCR_IDX_W         18
`define LCDCR_IDX_DCTL      18'h050A0
`define LCDCR_IDX_CADJ      18'h050A1
`define LCDCR_IDX_DUTY      18'h050A2
`define LCDCR_IDX_VREG      18'h050A3
`define LCDCR_IDX_PWR       18'h050A4
`define LCDCR_IDX_IMSK      18'h050A5
`define LCDCR_IDX_IFLG      18'h050A6
`define LCDCR_IDX_CKSEL     18'h050A7

`define LCDCR_DCTL_SEG      7
`define LCDCR_DCTL_COM      6
`define LCDCR_DCTL_AREA     5
`define LCDCR_DCTL_INV      4
`define LCDCR_DCTL_MODE_HI  1
`define LCDCR_DCTL_MODE_LO  0
`define LCDCR_VREG_HVLD     4
`define LCDCR_PWR_REGULATOR_SUPPLY_SELECT     1
`define LCDCR_PWR_BOOSTER_ON      0
`define LCDCR_IMSK_FRAME_IRQ_ENABLE    0
`define LCDCR_IFLG_FRAME_IRQ_FLAG    0
`define LCDCR_CKSEL_SRC     1

`define LCDCR_RST_SEG       1'b1
`define LCDCR_RST_COM       1'b1
`define LCDCR_RST_AREA      1'b0
`define LCDCR_RST_INV       1'b1
`define LCDCR_RST_MODE      2'h0
`define LCDCR_RST_CONTRAST  4'h0
`define LCDCR_RST_DUTY      2'h2
`define LCDCR_RST_HVLD      1'b0
`define LCDCR_RST_REGULATOR_SUPPLY_SELECT     1'b0
`define LCDCR_RST_BOOSTER_ON      1'b0
`define LCDCR_RST_FRAME_IRQ_ENABLE     1'b0
`define LCDCR_RST_FRAME_IRQ_FLAG     1'b0
`define LCDCR_RST_CKSRC     1'b1

`define LCDCR_DUTY_32       2'h2
`define LCDCR_DUTY_16       2'h1
`define LCDCR_LINES_32      5'h1F
`define LCDCR_LINES_16      5'h0F

`endif

// file: src/lcdcr_pkg.sv
// types shared by the lcd control register block
package lcdcr_pkg;
    typedef logic [7:0] lcdcr_byte_t;
    typedef enum logic [1:0] {
        LCDCR_DISP_OFF,
        LCDCR_DISP_NORMAL,
        LCDCR_DISP_ALL_ON,
        LCDCR_DISP_ALL_OFF
    } lcdcr_dispmode_t;
endpackage : lcdcr_pkg

// file: src/lcdcr_frame_timer.sv
// common line counter that marks the end of each lcd frame
`timescale 1ns/1ps
`include "lcdcr_consts.svh"
module lcdcr_frame_timer
    import lcdcr_pkg::*;
(
    input  wire logic       clk,          // system clock
    input  wire logic       resetn,       // async reset, active low
    input  wire logic       tick,         // one lcd clock step
    input  wire logic [1:0] duty_select,  // 1/16 or 1/32 duty
    output logic      [4:0] common_index, // current common line
    output logic            frame_event   // one-cycle end of frame
);
    logic [4:0] next_common_index;
    logic       next_frame_event;
    logic [4:0] last_line;

    always_comb begin
        last_line = (duty_select == `LCDCR_DUTY_16) ? `LCDCR_LINES_16
                                                    : `LCDCR_LINES_32;
        next_common_index = common_index;
        next_frame_event  = 1'b0;
        if (tick) begin
            // a duty change mid-frame may leave the index past the end
            if (common_index >= last_line) begin
                next_common_index = 5'h00;
                next_frame_event  = 1'b1;
            end else begin
                next_common_index = common_index + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            common_index <= 5'h00;
            frame_event  <= 1'b0;
        end else begin
            common_index <= next_common_index;
            frame_event  <= next_frame_event;
        end
    end
endmodule : lcdcr_frame_timer

// file: src/lcdcr_regs.sv
// apb register bank and display control outputs of the lcd driver
//
// Operation
// - segment, common, inversion bits: 1 normal, 0 reversed; reset 1
// - area-select bit picks display memory area 1 or 0; reset 0
// - mode field: 3 all off, 2 all on, 1 normal, 0 blank; reset 0
// - 4-bit contrast in bits 3..0, 0 lightest, f darkest; reset 0
// - duty 2 is 1/32, 1 is 1/16, reset 2; 0 and 3 forbidden
// - regulator bit 4 switches heavy-load protection; reset 0
// - supply select: 1 boosted second supply, 0 main; reset 0
// - booster control bit runs booster when 1; reset 0
// - frame interrupt enable at mask bit 0; reset 0
// - frame event sets flag; software writes 1 to clear it
// - lcd clock from low-speed oscillator when 1, else high-speed
`timescale 1ns/1ps
`include "lcdcr_consts.svh"
module lcdcr_regs
    import lcdcr_pkg::*;
(
    input  wire logic                     clk,       // 100 MHz clock
    input  wire logic                     resetn,    // async reset, low
    input  wire logic                     psel,      // apb select
    input  wire logic                     penable,   // apb access phase
    input  wire logic                     pwrite,    // apb write
    input  wire logic [`LCDCR_ADDR_W-1:0] paddr,     // apb byte address
    input  wire logic [31:0]              pwdata,    // apb write data
    output logic      [31:0]              prdata,    // apb read data
    output logic                          pready,    // apb ready
    output logic                          pslverr,   // unmapped access
    input  wire logic                     low_speed_oscillator,  // tick
    input  wire logic                     high_speed_oscillator, // tick
    output logic                          segment_order_normal,  // seg
    output logic                          common_order_normal,   // com
    output logic                          display_area_select,   // area
    output logic                          inverse_display_off,   // inv
    output logic      [1:0]               display_mode_field,    // mode
    output logic                          display_blank,   // all blank
    output logic                          display_all_on,  // force on
    output logic                          display_all_off, // force off
    output logic      [3:0]               contrast_level,  // contrast
    output logic      [1:0]               duty_select,     // duty
    output logic                          heavy_load_protect,      // hvld
    output logic                          regulator_supply_select, // vd
    output logic                          booster_on,              // pb
    output logic                          frame_irq_enable,        // ie
    output logic                          frame_irq_flag,          // if
    output logic                          lcd_clock_source_select, // src
    output logic                          lcd_clk_tick,    // lcd step
    output logic      [4:0]               common_index,    // line
    output logic                          frame_event,     // frame end
    output logic                          lcd_irq          // irq request
);
    logic [`LCDCR_IDX_W-1:0] idx;
    logic                    addr_ok;
    logic                    mapped;
    logic                    wr_en;
    logic                    rd_setup;
    logic                    wr_dctl;
    logic                    wr_cadj;
    logic                    wr_duty;
    logic                    wr_vreg;
    logic                    wr_pwr;
    logic                    wr_imsk;
    logic                    wr_iflg;
    logic                    wr_cksel;
    lcdcr_byte_t             rd_byte;

    // control state next values and the display mode register
    logic            next_seg;
    logic            next_com;
    logic            next_area;
    logic            next_inv;
    lcdcr_dispmode_t next_mode;
    logic [3:0]      next_contrast;
    logic [1:0]      next_duty;
    logic            next_hvld;
    logic            next_regulator_supply_select;
    logic            next_booster_on;
    logic            next_frame_irq_enable;
    logic            next_frame_irq_flag;
    logic            next_cksrc;
    lcdcr_dispmode_t mode;

    // bus answer and lcd tick next values
    logic [31:0]     next_prdata;
    logic            next_pslverr;
    logic            next_tick;

    assign idx      = paddr[`LCDCR_ADDR_W-1:2];
    assign addr_ok  = (paddr[1:0] == 2'h0);
    // writes land only at the completing edge; pready is always high
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready   = 1'b1;

    always_comb begin
        mapped = addr_ok;
        case (idx)
            `LCDCR_IDX_DCTL,
            `LCDCR_IDX_CADJ,
            `LCDCR_IDX_DUTY,
            `LCDCR_IDX_VREG,
            `LCDCR_IDX_PWR,
            `LCDCR_IDX_IMSK,
            `LCDCR_IDX_IFLG,
            `LCDCR_IDX_CKSEL: mapped = addr_ok;
            default:          mapped = 1'b0;
        endcase
    end

    assign wr_dctl  = wr_en & addr_ok & (idx == `LCDCR_IDX_DCTL);
    assign wr_cadj  = wr_en & addr_ok & (idx == `LCDCR_IDX_CADJ);
    assign wr_duty  = wr_en & addr_ok & (idx == `LCDCR_IDX_DUTY);
    assign wr_vreg  = wr_en & addr_ok & (idx == `LCDCR_IDX_VREG);
    assign wr_pwr   = wr_en & addr_ok & (idx == `LCDCR_IDX_PWR);
    assign wr_imsk  = wr_en & addr_ok & (idx == `LCDCR_IDX_IMSK);
    assign wr_iflg  = wr_en & addr_ok & (idx == `LCDCR_IDX_IFLG);
    assign wr_cksel = wr_en & addr_ok & (idx == `LCDCR_IDX_CKSEL);

    always_comb begin
        next_seg      = segment_order_normal;
        next_com      = common_order_normal;
        next_area     = display_area_select;
        next_inv      = inverse_display_off;
        next_mode     = mode;
        next_contrast = contrast_level;
        next_duty     = duty_select;
        next_hvld     = heavy_load_protect;
        next_regulator_supply_select    = regulator_supply_select;
        next_booster_on     = booster_on;
        next_frame_irq_enable    = frame_irq_enable;
        next_cksrc    = lcd_clock_source_select;
        if (wr_dctl) begin
            next_seg  = pwdata[`LCDCR_DCTL_SEG];
            next_com  = pwdata[`LCDCR_DCTL_COM];
            next_inv  = pwdata[`LCDCR_DCTL_INV];
            next_area = pwdata[`LCDCR_DCTL_AREA];
            next_mode = lcdcr_dispmode_t'(
                pwdata[`LCDCR_DCTL_MODE_HI:`LCDCR_DCTL_MODE_LO]);
        end
        if (wr_cadj) begin
            next_contrast = pwdata[3:0];
        end
        // reserved duty codes are dropped so the timer never sees them
        if (wr_duty && (pwdata[1:0] == `LCDCR_DUTY_32 ||
                        pwdata[1:0] == `LCDCR_DUTY_16)) begin
            next_duty = pwdata[1:0];
        end
        if (wr_vreg) begin
            next_hvld = pwdata[`LCDCR_VREG_HVLD];
        end
        if (wr_pwr) begin
            next_regulator_supply_select = pwdata[`LCDCR_PWR_REGULATOR_SUPPLY_SELECT];
            next_booster_on  = pwdata[`LCDCR_PWR_BOOSTER_ON];
        end
        if (wr_imsk) begin
            next_frame_irq_enable = pwdata[`LCDCR_IMSK_FRAME_IRQ_ENABLE];
        end
        if (wr_cksel) begin
            next_cksrc = pwdata[`LCDCR_CKSEL_SRC];
        end
        // a frame event in the clearing cycle wins over the clear
        next_frame_irq_flag = (frame_irq_flag &
                      ~(wr_iflg & pwdata[`LCDCR_IFLG_FRAME_IRQ_FLAG])) |
                     frame_event;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            segment_order_normal    <= `LCDCR_RST_SEG;
            common_order_normal     <= `LCDCR_RST_COM;
            display_area_select     <= `LCDCR_RST_AREA;
            inverse_display_off     <= `LCDCR_RST_INV;
            mode                    <= LCDCR_DISP_OFF;
            contrast_level          <= `LCDCR_RST_CONTRAST;
            duty_select             <= `LCDCR_RST_DUTY;
            heavy_load_protect      <= `LCDCR_RST_HVLD;
            regulator_supply_select <= `LCDCR_RST_REGULATOR_SUPPLY_SELECT;
            booster_on              <= `LCDCR_RST_BOOSTER_ON;
            frame_irq_enable        <= `LCDCR_RST_FRAME_IRQ_ENABLE;
            frame_irq_flag          <= `LCDCR_RST_FRAME_IRQ_FLAG;
            lcd_clock_source_select <= `LCDCR_RST_CKSRC;
        end else begin
            segment_order_normal    <= next_seg;
            common_order_normal     <= next_com;
            display_area_select     <= next_area;
            inverse_display_off     <= next_inv;
            mode                    <= next_mode;
            contrast_level          <= next_contrast;
            duty_select             <= next_duty;
            heavy_load_protect      <= next_hvld;
            regulator_supply_select <= next_regulator_supply_select;
            booster_on              <= next_booster_on;
            frame_irq_enable        <= next_frame_irq_enable;
            frame_irq_flag          <= next_frame_irq_flag;
            lcd_clock_source_select <= next_cksrc;
        end
    end

    assign display_mode_field = mode;
    assign display_blank      = (mode == LCDCR_DISP_OFF);
    assign display_all_on     = (mode == LCDCR_DISP_ALL_ON);
    assign display_all_off    = (mode == LCDCR_DISP_ALL_OFF);
    assign lcd_irq            = frame_irq_flag & frame_irq_enable;

    // read data is latched in the setup cycle so prdata comes from flops
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            `LCDCR_IDX_DCTL: rd_byte = {segment_order_normal,
                                        common_order_normal,
                                        display_area_select,
                                        inverse_display_off,
                                        2'h0, mode};
            `LCDCR_IDX_CADJ: rd_byte = {4'h0, contrast_level};
            `LCDCR_IDX_DUTY: rd_byte = {6'h00, duty_select};
            `LCDCR_IDX_VREG: rd_byte = {3'h0, heavy_load_protect, 4'h0};
            `LCDCR_IDX_PWR:  rd_byte = {6'h00, regulator_supply_select,
                                        booster_on};
            `LCDCR_IDX_IMSK: rd_byte = {7'h00, frame_irq_enable};
            `LCDCR_IDX_IFLG: rd_byte = {7'h00, frame_irq_flag};
            `LCDCR_IDX_CKSEL: rd_byte = {6'h00, lcd_clock_source_select,
                                         1'b0};
            default:         rd_byte = 8'h00;
        endcase
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (rd_setup) begin
            next_prdata  = (mapped && !pwrite) ? {24'h000000, rd_byte}
                                               : 32'h00000000;
            next_pslverr = ~mapped;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // both oscillator steps arrive as enables on the one system clock
    always_comb begin
        next_tick = lcd_clock_source_select ? low_speed_oscillator
                                            : high_speed_oscillator;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lcd_clk_tick <= 1'b0;
        end else begin
            lcd_clk_tick <= next_tick;
        end
    end

    lcdcr_frame_timer u_frame_timer (
        .clk          (clk),
        .resetn       (resetn),
        .tick         (lcd_clk_tick),
        .duty_select  (duty_select),
        .common_index (common_index),
        .frame_event  (frame_event)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    dctl_write_a: assert property (
        wr_dctl |=> segment_order_normal == $past(pwdata[7]) &&
                    common_order_normal == $past(pwdata[6]) &&
                    inverse_display_off == $past(pwdata[4]))
        else $error("display order bits not taken from write");
    area_write_a: assert property (
        wr_dctl |=> display_area_select == $past(pwdata[5]))
        else $error("area select not taken from write");
    mode_decode_a: assert property (
        display_all_on == (display_mode_field == 2'h2) &&
        display_all_off == (display_mode_field == 2'h3) &&
        display_blank == (display_mode_field == 2'h0))
        else $error("display mode decode wrong");
    contrast_hold_a: assert property (
        !wr_cadj |=> $stable(contrast_level))
        else $error("contrast changed without write");
    duty_legal_a: assert property (
        wr_duty && (pwdata[1:0] == 2'h0 || pwdata[1:0] == 2'h3)
        |=> $stable(duty_select) && duty_select != 2'h0)
        else $error("reserved duty code accepted");
    power_write_a: assert property (
        wr_vreg |=> heavy_load_protect == $past(pwdata[4]))
        else $error("heavy load bit not taken");
    booster_write_a: assert property (
        wr_pwr |=> booster_on == $past(pwdata[0]) &&
                   regulator_supply_select == $past(pwdata[1]))
        else $error("power bits not taken");
    irq_enable_a: assert property (
        wr_imsk |=> frame_irq_enable == $past(pwdata[0]))
        else $error("interrupt enable not taken");
    flag_set_a: assert property (
        frame_event |=> frame_irq_flag)
        else $error("frame event lost");
    flag_clear_a: assert property (
        wr_iflg && pwdata[0] && !frame_event |=> !frame_irq_flag)
        else $error("flag not cleared by write of one");
    flag_keep_a: assert property (
        frame_irq_flag && !(wr_iflg && pwdata[0]) |=> frame_irq_flag)
        else $error("flag dropped without clear");
    clk_source_a: assert property (
        lcd_clock_source_select && low_speed_oscillator |=> lcd_clk_tick)
        else $error("lcd tick not from low speed source");
    irq_out_a: assert property (
        lcd_irq == (frame_irq_flag && frame_irq_enable))
        else $error("interrupt request mismatch");

    frame_seen_c: cover property (frame_event ##1 lcd_irq);
    flag_clear_c: cover property (frame_irq_flag ##1 wr_iflg);
    all_on_c:     cover property (wr_dctl ##1 display_all_on);
    unmapped_c:   cover property (psel && penable && pslverr);
endmodule : lcdcr_regs

// file: tb/lcdcr_panel_model.sv
// oscillator tick sources feeding the lcd clock selector
`timescale 1ns/1ps
module lcdcr_panel_model #(
    parameter int LOW_GAP  = 5,
    parameter int HIGH_GAP = 2
) (
    input  wire logic clk,       // system clock
    input  wire logic resetn,    // async reset, active low
    input  wire logic run_low,   // let the low-speed source step
    input  wire logic run_high,  // let the high-speed source step
    output logic      low_tick,  // low-speed oscillator step
    output logic      high_tick  // high-speed oscillator step
);
    int low_cnt;
    int high_cnt;

    // free-running phase so a stopped source resumes on the same grid
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 0;
            high_cnt <= 0;
            low_tick <= 1'b0;
            high_tick <= 1'b0;
        end else begin
            low_cnt <= (low_cnt == LOW_GAP - 1) ? 0 : low_cnt + 1;
            high_cnt <= (high_cnt == HIGH_GAP - 1) ? 0 : high_cnt + 1;
            low_tick <= run_low && (low_cnt == LOW_GAP - 1);
            high_tick <= run_high && (high_cnt == HIGH_GAP - 1);
        end
    end
endmodule : lcdcr_panel_model

// file: tb/lcd_driver_control_regs_test.sv
// self-checking bench of the lcd control register block
`timescale 1ns/1ps
`include "lcdcr_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end end
module lcd_driver_control_regs_test;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        rerr, low_tick, high_tick, run_low, run_high;
    logic        segment_order_normal, common_order_normal;
    logic        display_area_select, inverse_display_off;
    logic        display_blank, display_all_on, display_all_off;
    logic        heavy_load_protect, regulator_supply_select, booster_on;
    logic        frame_irq_enable, frame_irq_flag, lcd_clock_source_select;
    logic        lcd_clk_tick, frame_event, lcd_irq;
    logic [1:0]  display_mode_field, duty_select;
    logic [3:0]  contrast_level;
    logic [4:0]  common_index;
    int          fail_count, checked, t0;
    int          ticks = 0;
    int          tick_cnt = 0;
    int          frame_len = 0;

    lcdcr_regs dut_u (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .low_speed_oscillator(low_tick),
        .high_speed_oscillator(high_tick), .segment_order_normal,
        .common_order_normal, .display_area_select, .inverse_display_off,
        .display_mode_field, .display_blank, .display_all_on,
        .display_all_off, .contrast_level, .duty_select,
        .heavy_load_protect, .regulator_supply_select, .booster_on,
        .frame_irq_enable, .frame_irq_flag, .lcd_clock_source_select,
        .lcd_clk_tick, .common_index, .frame_event, .lcd_irq
    );

    lcdcr_panel_model panel_u (
        .clk, .resetn, .run_low, .run_high, .low_tick, .high_tick
    );

    // lcd steps seen in total and between frame ends
    always @(posedge clk) begin
        ticks <= ticks + int'(lcd_clk_tick);
        if (frame_event === 1'b1) begin
            frame_len <= tick_cnt;
            tick_cnt <= int'(lcd_clk_tick);
        end else begin
            tick_cnt <= tick_cnt + int'(lcd_clk_tick);
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one apb transfer; psel stays up so a following call is back to back
    task automatic xfer(input logic w, input logic [17:0] idx,
                        input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        // answer is taken at the edge where pready is seen high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
    endtask : xfer

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : idle

    task automatic rd_chk(input logic [17:0] idx, input logic [7:0] e,
                          input string nm);
        xfer(1'b0, idx, 8'h00);
        `CHK(nm, {24'h0, e}, rdata)
    endtask : rd_chk

    task automatic wait_frame();
        do begin
            @(negedge clk);
        end while (frame_event !== 1'b1);
        @(posedge clk);
    endtask : wait_frame

    task automatic count_ticks(input int e, input string nm);
        repeat (4) idle();
        t0 = ticks;
        repeat (40) idle();
        `CHK(nm, e, ticks - t0)
        $display("test %s done", nm);
    endtask : count_ticks

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        fail_count++;
        test_done();
    end

    initial begin
        {resetn, psel, penable, pwrite, run_low, run_high} = 6'h00;
        paddr = 20'h00000;
        pwdata = 32'h00000000;
        fail_count = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_chk(`LCDCR_IDX_DCTL, 8'hD0, "dctl reset");
        rd_chk(`LCDCR_IDX_CADJ, 8'h00, "contrast reset");
        rd_chk(`LCDCR_IDX_DUTY, 8'h02, "duty reset");
        rd_chk(`LCDCR_IDX_VREG, 8'h00, "vreg reset");
        rd_chk(`LCDCR_IDX_PWR, 8'h00, "power reset");
        rd_chk(`LCDCR_IDX_IMSK, 8'h00, "enable reset");
        rd_chk(`LCDCR_IDX_IFLG, 8'h00, "flag reset");
        rd_chk(`LCDCR_IDX_CKSEL, 8'h02, "source reset");
        `CHK("order bits", 4'hE, {segment_order_normal, common_order_normal, inverse_display_off, display_area_select})
        $display("test reset done");
        // reserved bits 3..2 written high must read back low
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, `LCDCR_IDX_DCTL, 8'h2C | 8'(m));
            rd_chk(`LCDCR_IDX_DCTL, 8'h20 | 8'(m), "dctl");
            idle();
            `CHK("mode", {m[1:0], m == 0, m == 2, m == 3}, {display_mode_field, display_blank, display_all_on, display_all_off})
        end
        `CHK("order bits", 4'h1, {segment_order_normal, common_order_normal, inverse_display_off, display_area_select})
        xfer(1'b1, `LCDCR_IDX_CADJ, 8'hFF);
        rd_chk(`LCDCR_IDX_CADJ, 8'h0F, "contrast");
        idle();
        `CHK("contrast out", 4'hF, contrast_level)
        xfer(1'b1, `LCDCR_IDX_DUTY, 8'h01);
        rd_chk(`LCDCR_IDX_DUTY, 8'h01, "duty 16");
        // software must not use codes 0 and 3; here the refusal is probed
        xfer(1'b1, `LCDCR_IDX_DUTY, 8'h00);
        rd_chk(`LCDCR_IDX_DUTY, 8'h01, "duty code 0");
        xfer(1'b1, `LCDCR_IDX_DUTY, 8'h03);
        rd_chk(`LCDCR_IDX_DUTY, 8'h01, "duty code 3");
        xfer(1'b1, `LCDCR_IDX_VREG, 8'hFF);
        rd_chk(`LCDCR_IDX_VREG, 8'h10, "vreg");
        xfer(1'b1, `LCDCR_IDX_PWR, 8'hFF);
        rd_chk(`LCDCR_IDX_PWR, 8'h03, "power");
        idle();
        `CHK("power out", 3'h7, {heavy_load_protect, regulator_supply_select, booster_on})
        xfer(1'b1, `LCDCR_IDX_PWR, 8'h01);
        idle();
        `CHK("supply out", 2'h1, {regulator_supply_select, booster_on})
        xfer(1'b1, `LCDCR_IDX_IMSK, 8'hFF);
        rd_chk(`LCDCR_IDX_IMSK, 8'h01, "enable");
        xfer(1'b0, `LCDCR_IDX_CKSEL + 18'h1, 8'h00);
        `CHK("unmapped data", 32'h0, rdata)
        `CHK("unmapped error", 1'b1, rerr)
        $display("test registers done");
        xfer(1'b1, `LCDCR_IDX_CKSEL, 8'h00);
        run_high <= 1'b1;
        count_ticks(20, "high source");
        `CHK("source out", 1'b0, lcd_clock_source_select)
        xfer(1'b1, `LCDCR_IDX_CKSEL, 8'h02);
        count_ticks(0, "low source idle");
        run_low <= 1'b1;
        count_ticks(8, "low source");
        wait_frame();
        wait_frame();
        idle();
        `CHK("lines 16", 16, frame_len)
        `CHK("line index", 5'h00, common_index)
        `CHK("flag irq", 2'h3, {frame_irq_flag, lcd_irq})
        run_low <= 1'b0;
        xfer(1'b1, `LCDCR_IDX_IMSK, 8'h00);
        idle();
        `CHK("masked irq", 2'h2, {frame_irq_flag, lcd_irq})
        xfer(1'b1, `LCDCR_IDX_IFLG, 8'hFE);
        rd_chk(`LCDCR_IDX_IFLG, 8'h01, "flag write 0");
        xfer(1'b1, `LCDCR_IDX_IFLG, 8'h01);
        rd_chk(`LCDCR_IDX_IFLG, 8'h00, "flag clear");
        xfer(1'b1, `LCDCR_IDX_IMSK, 8'h01);
        idle();
        `CHK("idle irq", 2'h0, {frame_irq_flag, lcd_irq})
        $display("test frame flag done");
        xfer(1'b1, `LCDCR_IDX_DUTY, 8'h02);
        idle();
        run_low <= 1'b1;
        repeat (3) wait_frame();
        idle();
        `CHK("lines 32", 32, frame_len)
        $display("test duty 32 done");
        test_done();
    end
endmodule : lcd_driver_control_regs_test
